// file: shared/adcstc_pkg.sv
package adcstc_pkg;
  // register byte addresses
  localparam logic [7:0]  SCAN_CTRL_ADDR  = 8'h00;
  localparam logic [7:0]  INPUT_SEL_ADDR  = 8'h04;
  localparam logic [7:0]  SCAN_CSEL_ADDR  = 8'h08;
  localparam logic [7:0]  CMP_HIT_ADDR    = 8'h0C;
  localparam logic [7:0]  SEQ_CTRL_ADDR   = 8'h10;
  localparam logic [7:0]  STATUS_ADDR     = 8'h14;
  // scan control fields
  localparam int          AUTOSCAN_BIT    = 15;
  localparam int          LOWPWR_BIT      = 14;
  localparam int          BAND_GAP_REQUEST_BIT       = 12;
  localparam int          TIMODE_LSB      = 8;
  localparam int          WMODE_LSB       = 2;
  localparam int          CMODE_LSB       = 0;
  // sequence control fields (scan inputs control, sequences per interrupt)
  localparam int          SCANIN_BIT      = 4;
  localparam int          SPI_LSB         = 0;
  // writable masks, everything else reads zero
  localparam logic [31:0] SCAN_CTRL_MASK  = 32'h0000_D30F;
  localparam logic [31:0] INPUT_SEL_MASK  = 32'h0000_00FF;
  localparam logic [31:0] SCAN_CSEL_MASK  = 32'h780F_FFFF;
  localparam logic [31:0] CMP_HIT_MASK    = 32'h000F_FFFF;
  localparam logic [31:0] SEQ_CTRL_MASK   = 32'h0000_001F;
  localparam logic [31:0] RESET_VALUE     = 32'h0000_0000;
  localparam logic [4:0]  NEG_AVSS        = 5'h00;
  localparam logic [4:0]  POS_LAST_PIN    = 5'h13;
  localparam logic [4:0]  POS_VDD_CORE    = 5'h1B;
  localparam logic [4:0]  POS_BANDGAP     = 5'h1C;
  localparam logic [4:0]  POS_AVSS        = 5'h1D;
  localparam logic [4:0]  POS_AVDD        = 5'h1E;
  typedef enum logic [1:0] {
    CM_LESS    = 2'b00,
    CM_GREATER = 2'b01,
    CM_INSIDE  = 2'b10,
    CM_OUTSIDE = 2'b11
  } adcstc_cmode_t;
  typedef enum logic [1:0] {
    WM_LEGACY  = 2'b00,
    WM_SAVE    = 2'b01,
    WM_CMPONLY = 2'b10,
    WM_RSVD    = 2'b11
  } adcstc_wmode_t;
  typedef enum logic [1:0] {
    TI_NONE    = 2'b00,
    TI_SEQ     = 2'b01,
    TI_MATCH   = 2'b10,
    TI_BOTH    = 2'b11
  } adcstc_timode_t;
endpackage : adcstc_pkg

// file: hw/adcstc_top.sv
// Notes on behaviour
// RQ1: autoscan enable bit runs automatic scanning
// RQ2: low power bit drops power after scan
// RQ3: band gap requested while enabled and active
// RQ4: threshold interrupt mode selects interrupt cause
// RQ5: threshold mode only under autoscan, else count
// RQ6: compare-only mode discards results, reserved mode
// RQ7: save mode stores only on match
// RQ8: legacy mode stores every result
// RQ9: outside window compare mode
// RQ10: inside window compare mode
// RQ11: greater than compare mode
// RQ12: less than compare mode
// RQ13: negative select code zero is ground
// RQ14: positive codes route internal sources
// RQ15: positive codes select pin channels
// RQ16: scan bits include or skip channels
// RQ17: outside mode hit on write or match
// RQ18: other modes hit on match
// RQ19: interrupt every sequences-per-interrupt plus one
// RQ20: scan inputs control steps positive input
// RQ21: hits sticky until zero written, reset zero
// RQ22: reserved bits read zero, ignore writes
module adcstc_top #(
  parameter int RES_W = 12,
  parameter int NCH   = 32
) (
  input  wire logic              aclk,          // 50 MHz clock
  input  wire logic              aresetn,       // sync reset, low
  input  wire logic [7:0]        s_axi_awaddr,  // write address
  input  wire logic              s_axi_awvalid, // write address valid
  output logic                   s_axi_awready, // write address ready
  input  wire logic [31:0]       s_axi_wdata,   // write data
  input  wire logic [3:0]        s_axi_wstrb,   // byte enables
  input  wire logic              s_axi_wvalid,  // write data valid
  output logic                   s_axi_wready,  // write data ready
  output logic [1:0]             s_axi_bresp,   // write response
  output logic                   s_axi_bvalid,  // write response valid
  input  wire logic              s_axi_bready,  // write response ready
  input  wire logic [7:0]        s_axi_araddr,  // read address
  input  wire logic              s_axi_arvalid, // read address valid
  output logic                   s_axi_arready, // read address ready
  output logic [31:0]            s_axi_rdata,   // read data
  output logic [1:0]             s_axi_rresp,   // read response
  output logic                   s_axi_rvalid,  // read data valid
  input  wire logic              s_axi_rready,  // read data ready
  input  wire logic              conv_enable,   // converter enabled
  input  wire logic              conv_active,   // converter active
  input  wire logic              conv_done,     // result valid pulse
  input  wire logic [RES_W-1:0]  conv_result,   // conversion result
  input  wire logic [RES_W-1:0]  conv_buf_lo,   // channel buffer value
  input  wire logic [RES_W-1:0]  conv_buf_hi,   // pair buffer value
  input  wire logic              seq_start,     // sequence start pulse
  input  wire logic              seq_end,       // sequence end pulse
  output logic [4:0]             pos_mux,       // positive input select
  output logic [2:0]             neg_mux,       // negative input select
  output logic                   autoscan_on,   // automatic scanning
  output logic                   low_power,     // low power request
  output logic                   band_gap_req,  // band gap request
  output logic                   result_store,  // store result pulse
  output logic                   int_pulse      // interrupt event pulse
);
  logic [31:0] scan_ctrl_reg;
  logic [31:0] input_sel_reg;
  logic [31:0] scan_csel_reg;
  logic [31:0] cmp_hit_reg;
  logic [31:0] seq_ctrl_reg;
  logic [4:0]  scan_ch_reg;
  logic [4:0]  scan_ch_next;
  logic [3:0]  seq_cnt_reg;
  logic        seen_match_reg;
  logic        scan_done_reg;
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_fire;
  logic        match;
  logic        seq_irq;
  logic        thr_irq;

  adcstc_pkg::adcstc_cmode_t  cmode;
  adcstc_pkg::adcstc_wmode_t  wmode;
  adcstc_pkg::adcstc_timode_t timode;
  logic [3:0] spi_cnt;
  logic       scan_in;

  assign cmode   = adcstc_pkg::adcstc_cmode_t'(
                     scan_ctrl_reg[adcstc_pkg::CMODE_LSB +: 2]);
  assign wmode   = adcstc_pkg::adcstc_wmode_t'(
                     scan_ctrl_reg[adcstc_pkg::WMODE_LSB +: 2]);
  assign timode  = adcstc_pkg::adcstc_timode_t'(
                     scan_ctrl_reg[adcstc_pkg::TIMODE_LSB +: 2]);
  assign spi_cnt = seq_ctrl_reg[adcstc_pkg::SPI_LSB +: 4];
  assign scan_in = seq_ctrl_reg[adcstc_pkg::SCANIN_BIT];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] din,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        v[b*8 +: 8] = din[b*8 +: 8];
      end
    end
    return v & mask; // [RQ22]
  endfunction : merge

  // write channel: address and data captured in either order
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
  assign wr_fire       = aw_hold_reg && w_hold_reg;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_rresp   = 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // unmapped writes are accepted with OKAY and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_ctrl_reg <= adcstc_pkg::RESET_VALUE; // [RQ21]
      input_sel_reg <= adcstc_pkg::RESET_VALUE;
      scan_csel_reg <= adcstc_pkg::RESET_VALUE;
      seq_ctrl_reg  <= adcstc_pkg::RESET_VALUE;
    end else if (wr_fire) begin
      case (awaddr_reg)
        adcstc_pkg::SCAN_CTRL_ADDR: begin
          scan_ctrl_reg <= merge(scan_ctrl_reg, wdata_reg, wstrb_reg,
                                 adcstc_pkg::SCAN_CTRL_MASK);
        end
        adcstc_pkg::INPUT_SEL_ADDR: begin
          input_sel_reg <= merge(input_sel_reg, wdata_reg, wstrb_reg,
                                 adcstc_pkg::INPUT_SEL_MASK);
        end
        adcstc_pkg::SCAN_CSEL_ADDR: begin
          scan_csel_reg <= merge(scan_csel_reg, wdata_reg, wstrb_reg,
                                 adcstc_pkg::SCAN_CSEL_MASK); // [RQ16]
        end
        adcstc_pkg::SEQ_CTRL_ADDR: begin
          seq_ctrl_reg <= merge(seq_ctrl_reg, wdata_reg, wstrb_reg,
                                adcstc_pkg::SEQ_CTRL_MASK);
        end
        default: begin
        end
      endcase
    end
  end

  // read channel: one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        adcstc_pkg::SCAN_CTRL_ADDR: s_axi_rdata <= scan_ctrl_reg;
        adcstc_pkg::INPUT_SEL_ADDR: s_axi_rdata <= input_sel_reg;
        adcstc_pkg::SCAN_CSEL_ADDR: s_axi_rdata <= scan_csel_reg;
        adcstc_pkg::CMP_HIT_ADDR:   s_axi_rdata <= cmp_hit_reg;
        adcstc_pkg::SEQ_CTRL_ADDR:  s_axi_rdata <= seq_ctrl_reg;
        adcstc_pkg::STATUS_ADDR: begin
          s_axi_rdata <= {22'h000000, scan_done_reg, seq_cnt_reg,
                          scan_ch_reg};
        end
        default:                    s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // compare of the result against the channel's buffer value or pair
  always_comb begin
    case (cmode)
      adcstc_pkg::CM_LESS:    match = conv_result < conv_buf_lo;  // [RQ12]
      adcstc_pkg::CM_GREATER: match = conv_result > conv_buf_lo;  // [RQ11]
      adcstc_pkg::CM_INSIDE:  match = conv_result >= conv_buf_lo &&
                                      conv_result <= conv_buf_hi; // [RQ10]
      adcstc_pkg::CM_OUTSIDE: match = conv_result < conv_buf_lo ||
                                      conv_result > conv_buf_hi;  // [RQ9]
      default:                match = 1'b0;
    endcase
  end

  // result store gating; reserved write mode never stores
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_store <= 1'b0;
    end else begin
      case (wmode)
        adcstc_pkg::WM_LEGACY:  result_store <= conv_done;          // [RQ8]
        adcstc_pkg::WM_SAVE:    result_store <= conv_done && match; // [RQ7]
        adcstc_pkg::WM_CMPONLY: result_store <= 1'b0;               // [RQ6]
        default:                result_store <= 1'b0;               // [RQ6]
      endcase
    end
  end

  // hit flags: a hardware set beats a software zero in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_hit_reg <= adcstc_pkg::RESET_VALUE; // [RQ21]
    end else begin
      logic [31:0] hv;
      hv = cmp_hit_reg;
      if (wr_fire && awaddr_reg == adcstc_pkg::CMP_HIT_ADDR) begin
        hv = merge(cmp_hit_reg, wdata_reg & cmp_hit_reg, wstrb_reg,
                   adcstc_pkg::CMP_HIT_MASK); // [RQ21]
      end
      if (conv_done && scan_ch_reg <= adcstc_pkg::POS_LAST_PIN) begin
        if (match || (cmode == adcstc_pkg::CM_OUTSIDE &&
                      wmode == adcstc_pkg::WM_LEGACY)) begin
          hv[scan_ch_reg] = 1'b1; // [RQ17] [RQ18]
        end
      end
      cmp_hit_reg <= hv;
    end
  end

  // next selected scan channel above the current one, wrapping
  always_comb begin
    logic [4:0] c;
    c = scan_ch_reg;
    scan_ch_next = scan_ch_reg;
    for (int i = 1; i <= NCH; i++) begin
      c = 5'(scan_ch_reg + 5'(i));
      if (scan_csel_reg[c] && scan_ch_next == scan_ch_reg) begin
        scan_ch_next = c;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_ch_reg <= 5'h00;
    end else if (!scan_in) begin
      scan_ch_reg <= input_sel_reg[4:0]; // [RQ20]
    end else if (conv_done) begin
      scan_ch_reg <= scan_ch_next; // [RQ20] [RQ16]
    end
  end

  // positive mux: pins 0..19 direct, internal sources at top codes
  assign pos_mux = scan_ch_reg; // [RQ14] [RQ15]
  assign neg_mux = adcstc_pkg::NEG_AVSS[2:0]; // [RQ13]

  // sequence counter and threshold tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_cnt_reg    <= 4'h0;
      seen_match_reg <= 1'b0;
      scan_done_reg  <= 1'b0;
    end else begin
      if (seq_end) begin
        seq_cnt_reg <= (seq_cnt_reg >= spi_cnt) ? 4'h0
                                                : 4'(seq_cnt_reg + 4'h1);
      end
      if (seq_start) begin
        seen_match_reg <= 1'b0;
        scan_done_reg  <= 1'b0;
      end
      if (conv_done && match) begin
        seen_match_reg <= 1'b1;
      end
      if (seq_end) begin
        scan_done_reg <= 1'b1;
      end
    end
  end

  // a count lowered below the running tally fires at once, never wraps
  assign seq_irq = seq_end && seq_cnt_reg >= spi_cnt; // [RQ19]

  always_comb begin
    case (timode)
      adcstc_pkg::TI_NONE:  thr_irq = 1'b0;                       // [RQ4]
      adcstc_pkg::TI_SEQ:   thr_irq = seq_end;                    // [RQ4]
      adcstc_pkg::TI_MATCH: thr_irq = conv_done && match;         // [RQ4]
      adcstc_pkg::TI_BOTH:  thr_irq = seq_end &&
                                      (seen_match_reg ||
                                       (conv_done && match));     // [RQ4]
      default:              thr_irq = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_pulse <= 1'b0;
    end else begin
      int_pulse <= autoscan_on ? thr_irq : seq_irq; // [RQ5]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      autoscan_on  <= 1'b0;
      low_power    <= 1'b0;
      band_gap_req <= 1'b0;
    end else begin
      autoscan_on  <= scan_ctrl_reg[adcstc_pkg::AUTOSCAN_BIT]; // [RQ1]
      low_power    <= scan_ctrl_reg[adcstc_pkg::LOWPWR_BIT] &&
                      scan_done_reg; // [RQ2]
      band_gap_req <= scan_ctrl_reg[adcstc_pkg::BAND_GAP_REQUEST_BIT] &&
                      conv_enable && conv_active; // [RQ3]
    end
  end

  property p_store_legacy;
    @(posedge aclk) disable iff (!aresetn)
      (wmode == adcstc_pkg::WM_LEGACY && conv_done) |=> result_store;
  endproperty
  legacy_store_a: assert property (p_store_legacy) // [RQ8]
    else $error("legacy result not stored");
  cmponly_nostore_a: assert property ( // [RQ6]
    @(posedge aclk) disable iff (!aresetn)
      $past(wmode) == adcstc_pkg::WM_CMPONLY |-> !result_store)
    else $error("compare-only mode stored");
  save_gated_a: assert property ( // [RQ7]
    @(posedge aclk) disable iff (!aresetn)
      (wmode == adcstc_pkg::WM_SAVE && conv_done && !match)
        |=> !result_store)
    else $error("save mode stored without match");
  hit_sticky_a: assert property ( // [RQ21]
    @(posedge aclk) disable iff (!aresetn)
      (cmp_hit_reg[0] && !wr_fire) |=> cmp_hit_reg[0])
    else $error("hit flag dropped");
  hit_set_a: assert property ( // [RQ18]
    @(posedge aclk) disable iff (!aresetn)
      (conv_done && match && scan_ch_reg == 5'h05) |=> cmp_hit_reg[5])
    else $error("hit flag not set");
  bandgap_a: assert property ( // [RQ3]
    @(posedge aclk) disable iff (!aresetn)
      band_gap_req |-> $past(conv_enable) && $past(conv_active))
    else $error("band gap requested while idle");
  autoscan_a: assert property ( // [RQ1]
    @(posedge aclk) disable iff (!aresetn)
      autoscan_on == $past(scan_ctrl_reg[adcstc_pkg::AUTOSCAN_BIT]))
    else $error("autoscan out of step");
  seq_irq_a: assert property ( // [RQ19]
    @(posedge aclk) disable iff (!aresetn)
      (!autoscan_on && seq_end && spi_cnt == 4'h0) |=> int_pulse)
    else $error("missed sequence interrupt");
  nointr_a: assert property ( // [RQ4]
    @(posedge aclk) disable iff (!aresetn)
      (autoscan_on && timode == adcstc_pkg::TI_NONE) |=> !int_pulse)
    else $error("interrupt in no-interrupt mode");
  reserved_zero_a: assert property ( // [RQ22]
    @(posedge aclk) disable iff (!aresetn)
      (scan_ctrl_reg & ~adcstc_pkg::SCAN_CTRL_MASK) == 32'h0000_0000)
    else $error("reserved bit set");
  write_cov: cover property (@(posedge aclk) wr_fire);
  store_cov: cover property (@(posedge aclk) result_store);
  irq_cov:   cover property (@(posedge aclk) int_pulse && autoscan_on);
endmodule : adcstc_top

// file: test/adcstc_core_model.sv
// stands in for the sample-and-hold and conversion core
module adcstc_core_model #(
  parameter int RES_W = 12
) (
  input  wire logic             aclk,        // core clock
  output logic                  conv_enable, // converter enabled
  output logic                  conv_active, // converter active
  output logic                  conv_done,   // result valid pulse
  output logic [RES_W-1:0]      conv_result, // conversion result
  output logic [RES_W-1:0]      conv_buf_lo, // channel buffer value
  output logic [RES_W-1:0]      conv_buf_hi, // pair buffer value
  output logic                  seq_start,   // sequence start pulse
  output logic                  seq_end      // sequence end pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {conv_enable, conv_active, conv_done, seq_start, seq_end} = 5'h00;
    {conv_result, conv_buf_lo, conv_buf_hi} = '0;
  end
  task automatic power(input logic en, input logic act);
    @(posedge aclk);
    conv_enable <= en;
    conv_active <= act;
  endtask : power
  // one sequence of one conversion; gap adds idle cycles before seq_start
  task automatic convert(input logic [RES_W-1:0] r, input logic [RES_W-1:0] lo,
                         input logic [RES_W-1:0] hi, input int gap);
    repeat (gap + 1) @(posedge aclk);
    seq_start <= 1'b1;
    @(posedge aclk);
    seq_start   <= 1'b0;
    conv_done   <= 1'b1;
    conv_result <= r;
    conv_buf_lo <= lo;
    conv_buf_hi <= hi;
    @(posedge aclk);
    // data is only valid with the pulse, so show garbage afterwards
    conv_done   <= 1'b0;
    conv_result <= ~r;
    conv_buf_lo <= ~lo;
    conv_buf_hi <= ~hi;
    seq_end     <= 1'b1;
    @(posedge aclk);
    seq_end <= 1'b0;
  endtask : convert
endmodule : adcstc_core_model

// file: test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CTL = adcstc_pkg::SCAN_CTRL_ADDR;
  localparam logic [7:0] A_SEL = adcstc_pkg::INPUT_SEL_ADDR;
  localparam logic [7:0] A_CSS = adcstc_pkg::SCAN_CSEL_ADDR;
  localparam logic [7:0] A_HIT = adcstc_pkg::CMP_HIT_ADDR;
  localparam logic [7:0] A_SEQ = adcstc_pkg::SEQ_CTRL_ADDR;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        conv_enable, conv_active, conv_done, seq_start, seq_end;
  logic [11:0] conv_result, conv_buf_lo, conv_buf_hi;
  logic [4:0]  pos_mux;
  logic [2:0]  neg_mux;
  logic        autoscan_on, low_power, band_gap_req, result_store, int_pulse;
  int          bad_count = 0;
  int          n_tests = 0;
  int          n_store = 0;
  int          n_int = 0;
  int          cycles = 0;
  adcstc_top #(.RES_W(12)) uut (.*);
  adcstc_core_model #(.RES_W(12)) core (.*);
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    if (result_store === 1'b1) n_store++;
    if (int_pulse === 1'b1) n_int++;
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic       aw, w, b;
    logic [1:0] rs;
    b  = 1'b0;
    rs = 2'h0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b) begin
      #1;
      aw = s_axi_awvalid && (s_axi_awready === 1'b1);
      w  = s_axi_wvalid && (s_axi_wready === 1'b1);
      b  = (s_axi_bvalid === 1'b1);
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check(32'(b), 32'h1, "write answer");
    check(32'(rs), 32'h0, "write resp");
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    logic       ar, r;
    logic [1:0] rs;
    r  = 1'b0;
    rs = 2'h0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r) begin
      #1;
      ar = s_axi_arvalid && (s_axi_arready === 1'b1);
      r  = (s_axi_rvalid === 1'b1);
      d  = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check(32'(r), 32'h1, "read answer");
    check(32'(rs), 32'h0, "read resp");
  endtask : axi_read
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axi_read(a, d);
    check(d, exp, "register read");
  endtask : rd_chk
  task automatic t_regs();
    logic [7:0]  ad [4] = '{A_CTL, A_SEL, A_CSS, A_SEQ};
    logic [31:0] mk [4] = '{adcstc_pkg::SCAN_CTRL_MASK,
                            adcstc_pkg::INPUT_SEL_MASK,
                            adcstc_pkg::SCAN_CSEL_MASK,
                            adcstc_pkg::SEQ_CTRL_MASK};
    for (int a = 0; a < 24; a += 4) rd_chk(8'(a), 32'h0);
    check({autoscan_on, low_power, band_gap_req, pos_mux, neg_mux}, 0,
          "rst");
    for (int i = 0; i < 4; i++) begin
      axi_write(ad[i], 32'hFFFF_FFFF);
      rd_chk(ad[i], mk[i]);
      axi_write(ad[i], 32'h0);
    end
    axi_write(A_HIT, 32'hFFFF_FFFF);
    rd_chk(A_HIT, 32'h0);
    axi_write(8'h18, 32'hFFFF_FFFF);
    rd_chk(8'h18, 32'h0);
  endtask : t_regs
  task automatic t_levels();
    axi_write(A_CTL, 32'h8000);
    repeat (2) @(posedge aclk);
    check(32'(autoscan_on), 1, "autoscan");
    core.convert(12'h032, 12'h064, 12'h0C8, 0);
    axi_write(A_CTL, 32'h4000);
    repeat (2) @(posedge aclk);
    check(32'(low_power), 1, "low power");
    core.power(1'b1, 1'b0);
    axi_write(A_CTL, 32'h1000);
    repeat (2) @(posedge aclk);
    check({autoscan_on, low_power, band_gap_req}, 0, "bg");
    core.power(1'b1, 1'b1);
    repeat (2) @(posedge aclk);
    check(32'(band_gap_req), 1, "bg active");
    core.power(1'b0, 1'b1);
    repeat (2) @(posedge aclk);
    check(32'(band_gap_req), 0, "bg disabled");
    axi_write(A_CTL, 32'h0);
  endtask : t_levels
  task automatic t_select();
    logic [4:0] codes [6] = '{5'h1E, 5'h1D, 5'h1C, 5'h1B, 5'h13, 5'h05};
    foreach (codes[i]) begin
      axi_write(A_SEL, {27'h0, codes[i]});
      repeat (2) @(posedge aclk);
      check({neg_mux, pos_mux}, {3'h0, codes[i]}, "mux");
    end
  endtask : t_select
  // channel 5 is selected; buffer window is 0x064..0x0C8
  task automatic cmp_case(input logic [1:0] wm, input logic [1:0] cm,
                          input logic [11:0] r, input logic hit,
                          input logic st);
    logic [31:0] d;
    int          s0;
    axi_write(A_HIT, 32'h0);
    axi_write(A_CTL, {28'h0, wm, cm});
    s0 = n_store;
    core.convert(r, 12'h064, 12'h0C8, 3);
    repeat (3) @(posedge aclk);
    axi_read(A_HIT, d);
    check(d, hit ? 32'h20 : 32'h0, "hit flags");
    check(32'(n_store - s0), 32'(st), "store count");
  endtask : cmp_case
  task automatic t_compare();
    cmp_case(2'b01, 2'b00, 12'h032, 1'b1, 1'b1);
    cmp_case(2'b01, 2'b00, 12'h096, 1'b0, 1'b0);
    cmp_case(2'b01, 2'b01, 12'h096, 1'b1, 1'b1);
    cmp_case(2'b01, 2'b01, 12'h032, 1'b0, 1'b0);
    cmp_case(2'b01, 2'b10, 12'h096, 1'b1, 1'b1);
    cmp_case(2'b01, 2'b10, 12'h0FA, 1'b0, 1'b0);
    cmp_case(2'b01, 2'b11, 12'h0FA, 1'b1, 1'b1);
    cmp_case(2'b01, 2'b11, 12'h096, 1'b0, 1'b0);
    cmp_case(2'b00, 2'b00, 12'h096, 1'b0, 1'b1);
    cmp_case(2'b00, 2'b11, 12'h096, 1'b1, 1'b1);
    cmp_case(2'b10, 2'b00, 12'h032, 1'b1, 1'b0);
    core.convert(12'h096, 12'h064, 12'h0C8, 0);
    axi_write(A_HIT, 32'h20);
    rd_chk(A_HIT, 32'h20);
  endtask : t_compare
  task automatic t_irq();
    int i0;
    axi_write(A_SEQ, 32'h2);
    axi_write(A_CTL, 32'h0300);
    i0 = n_int;
    repeat (2) core.convert(12'h032, 12'h064, 12'h0C8, 0);
    repeat (3) @(posedge aclk);
    check(32'(n_int - i0), 0, "count early");
    core.convert(12'h032, 12'h064, 12'h0C8, 0);
    repeat (3) @(posedge aclk);
    check(32'(n_int - i0), 1, "count third");
    axi_write(A_SEQ, 32'h0);
    for (int m = 0; m < 8; m++) begin
      axi_write(A_CTL, 32'h8009 | 32'((m >> 1) << 8));
      i0 = n_int;
      core.convert((m & 1) ? 12'h096 : 12'h032, 12'h064, 12'h0C8, 0);
      repeat (3) @(posedge aclk);
      check(32'(n_int - i0), 32'((m > 1 && m < 4) || (m > 3 && (m & 1))),
            "threshold irq");
    end
    axi_write(A_CTL, 32'h0);
  endtask : t_irq
  task automatic t_scan();
    logic [4:0] p [3];
    axi_write(A_CSS, 32'h84);
    axi_write(A_SEQ, 32'h10);
    foreach (p[i]) begin
      core.convert(12'h032, 12'h064, 12'h0C8, 1);
      repeat (2) @(posedge aclk);
      p[i] = pos_mux;
    end
    // channel 5 is the start, so the next selected above it is 7
    check(p[0], 5'h07, "scan step");
    check(p[1], 5'h02, "scan next");
    check(p[2], p[0], "scan wrap");
    axi_write(A_SEQ, 32'h0);
  endtask : t_scan
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_levels();
    t_select();
    t_compare();
    t_irq();
    t_scan();
    summarize();
  end
endmodule : tb_top
